//--- rtl/rsw_cmd.sv
// ascii command interpreter for the 32-channel relay switch
`timescale 1ns/1ps
module rsw_cmd
   import rsw_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   output logic             rx_ready_o,
   output logic [7:0]       tx_data_o,
   output logic             tx_valid_o,
   input  wire logic        tx_ready_i,
   output logic [31:0]      relay_o,
   output logic [31:0]      chan_lamp_o,
   output logic             supply_lamp_o
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   localparam int MSW = $clog2(CYC_MS + 1);

   rsw_state_t             state_reg;
   rsw_state_t             nxt_reg;
   logic [7:0]             ch_reg;
   logic [7:0]             cmd_reg;
   logic                   cmd_v_reg;
   logic [DELAY_W-1:0]     acc_reg;
   logic                   has_dig_reg;
   logic                   ovf_reg;
   logic [DELAY_W-1:0]     delay_reg;
   logic [NUM_CHAN-1:0]    relays_reg;
   logic [NUM_CHAN-1:0]    lamps_reg;
   logic                   gap_reg;
   logic [MSW-1:0]         cyc_reg;
   logic [DELAY_W-1:0]     ms_reg;
   logic [DELAY_W-1:0]     rem_reg;
   logic [2:0]             idx_reg;
   logic [3:0]             dig_reg;
   logic                   lead_reg;
   logic [7:0]             out_reg;
   logic                   rx_ready_reg;
   logic                   lamp_reg;

   rsw_stream_if #(.W(8)) rep_in ();
   rsw_stream_if #(.W(8)) rep_out ();

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire        is_digit  = (ch_reg >= CHR_ZERO) && (ch_reg <= CHR_NINE);
   wire [3:0]  digit     = 4'(ch_reg - CHR_ZERO);
   wire [20:0] acc_mul   = 21'(acc_reg) * 21'd10 + 21'(digit);
   wire        acc_big   = acc_mul > 21'(16'hffff);
   // strict letters only: lower case is not a command
   wire        is_cmd    = (ch_reg == CHR_SET) || (ch_reg == CHR_RST)
                        || (ch_reg == CHR_CLOSE) || (ch_reg == CHR_OPEN)
                        || (ch_reg == CHR_QUERY) || (ch_reg == CHR_DELAY)
                        || (ch_reg == CHR_TIME); // [RULE_03]
   wire        is_relay  = (cmd_reg == CHR_SET) || (cmd_reg == CHR_RST)
                        || (cmd_reg == CHR_CLOSE) || (cmd_reg == CHR_OPEN);
   wire        needs_ch  = (cmd_reg == CHR_CLOSE) || (cmd_reg == CHR_OPEN)
                        || (cmd_reg == CHR_QUERY);
   // channel numbers above 31 and overlong arguments are caught before execution
   wire        chan_ok   = has_dig_reg && !ovf_reg
                        && (acc_reg < DELAY_W'(NUM_CHAN)); // [RULE_10] [RULE_13]
   wire        cmd_ok    = needs_ch ? chan_ok : 1'b1;
   wire [4:0]  chan      = acc_reg[4:0];
   wire        must_wait = is_relay && cmd_ok && gap_reg
                        && (delay_reg != '0); // [RULE_11]
   wire        ms_tick   = (cyc_reg == MSW'(CYC_MS - 1));
   wire        rx_take   = rx_valid_i && rx_ready_reg;
   wire        push_ok   = rep_in.ready;

   logic [DELAY_W-1:0] pow;
   always_comb begin
      case (idx_reg)
         3'd0:    pow = 16'd10000;
         3'd1:    pow = 16'd1000;
         3'd2:    pow = 16'd100;
         3'd3:    pow = 16'd10;
         default: pow = 16'd1;
      endcase
   end
   wire dig_more = rem_reg >= pow;
   // leading zeros are skipped, but the last place always prints so a zero delay reads 0
   wire last_dig = (idx_reg == 3'(NUM_DIGITS - 1));
   wire dig_emit = (dig_reg != '0) || !lead_reg || last_dig;

   // relay image after the executing command, one bit per channel
   wire [NUM_CHAN-1:0] relays_next;
   generate
      for (genvar n = 0; n < NUM_CHAN; n++) begin : g_chan
         wire hit = (chan == 5'(n));
         wire set_bit = (cmd_reg == CHR_SET)                 // [RULE_05]
                     || ((cmd_reg == CHR_CLOSE) && hit);     // [RULE_07]
         wire clr_bit = (cmd_reg == CHR_RST)                 // [RULE_06]
                     || ((cmd_reg == CHR_OPEN) && hit);      // [RULE_08]
         assign relays_next[n] = set_bit ? 1'b1 : clr_bit ? 1'b0 : relays_reg[n];
      end
   endgenerate

   // -----------------------------------------------------------------
   // reply path
   // -----------------------------------------------------------------
   assign rep_in.valid = (state_reg == RSW_DATA) || (state_reg == RSW_CR)
                      || (state_reg == RSW_LF);
   assign rep_in.data  = (state_reg == RSW_CR) ? CHR_CR
                       : (state_reg == RSW_LF) ? CHR_LF : out_reg; // [RULE_02]
   assign rep_out.ready = tx_ready_i;

   // the buffer head is a flop, so the reply outputs stay registered
   rsw_buf u_buf (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .in_s    (rep_in.snk),
      .out_s   (rep_out.src)
   );

   assign tx_data_o     = rep_out.data;
   assign tx_valid_o    = rep_out.valid;
   assign rx_ready_o    = rx_ready_reg;
   assign relay_o       = relays_reg;
   assign chan_lamp_o   = lamps_reg;
   assign supply_lamp_o = lamp_reg;

   // -----------------------------------------------------------------
   // relay, lamp and delay storage
   // -----------------------------------------------------------------
   // lamps get flops of their own so their drive never loads the coil path
   wire apply_relay = (state_reg == RSW_EXEC) && !must_wait && is_relay && cmd_ok;
   wire load_delay  = (state_reg == RSW_EXEC) && (cmd_reg == CHR_DELAY)
                   && has_dig_reg && !ovf_reg; // [RULE_13]

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         relays_reg <= RELAYS_RST; // [RULE_04]
         lamps_reg  <= RELAYS_RST; // [RULE_04]
      end else if (apply_relay) begin
         relays_reg <= relays_next;
         lamps_reg  <= relays_next; // [RULE_05] [RULE_06]
      end
   end

   // an empty or overlong delay argument leaves the old delay in place
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         delay_reg <= DELAY_RST;
      end else if (load_delay) begin
         delay_reg <= acc_reg; // [RULE_11]
      end
   end

   // -----------------------------------------------------------------
   // delay timer: a millisecond prescaler and a millisecond count
   // -----------------------------------------------------------------
   // the prescaler restarts on every wait so each gap is a whole number of ms
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cyc_reg <= '0;
         ms_reg  <= '0;
      end else if (state_reg != RSW_WAIT) begin
         cyc_reg <= '0;
         ms_reg  <= delay_reg;
      end else if (ms_tick) begin
         cyc_reg <= '0;
         ms_reg  <= ms_reg - 1'b1; // [RULE_11]
      end else begin
         cyc_reg <= cyc_reg + 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // command sequencer
   // -----------------------------------------------------------------
   // reset leaves every relay released and the supply lamp lit next edge
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         lamp_reg <= 1'b0;
      end else begin
         lamp_reg <= 1'b1; // [RULE_04]
      end
   end

   // a command runs when the next non-digit arrives, so its argument is whole
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg    <= RSW_GET;
         nxt_reg      <= RSW_GET;
         ch_reg       <= '0;
         cmd_reg      <= '0;
         cmd_v_reg    <= 1'b0;
         acc_reg      <= '0;
         has_dig_reg  <= 1'b0;
         ovf_reg      <= 1'b0;
         gap_reg      <= 1'b0;
         rem_reg      <= '0;
         idx_reg      <= '0;
         dig_reg      <= '0;
         lead_reg     <= 1'b1;
         out_reg      <= '0;
         rx_ready_reg <= 1'b1;
      end else begin
         case (state_reg)
            RSW_GET: begin
               if (rx_take) begin
                  ch_reg       <= rx_data_i;
                  rx_ready_reg <= 1'b0;
                  state_reg    <= RSW_PARSE;
               end
            end
            RSW_PARSE: begin
               if (cmd_v_reg && is_digit) begin
                  acc_reg      <= acc_mul[DELAY_W-1:0];
                  ovf_reg      <= ovf_reg | acc_big;
                  has_dig_reg  <= 1'b1;
                  rx_ready_reg <= 1'b1;
                  state_reg    <= RSW_GET;
               end else if (cmd_v_reg) begin
                  // a non-digit closes the argument; the character is kept
                  state_reg <= RSW_EXEC;
               end else begin
                  if (is_cmd) begin
                     cmd_reg     <= ch_reg;
                     cmd_v_reg   <= 1'b1;
                     acc_reg     <= '0;
                     has_dig_reg <= 1'b0;
                     ovf_reg     <= 1'b0;
                  end else if (ch_reg == CHR_LF) begin
                     gap_reg <= 1'b0; // [RULE_01]
                  end
                  // stray cr before lf and unknown letters are dropped
                  rx_ready_reg <= 1'b1; // [RULE_01] [RULE_13]
                  state_reg    <= RSW_GET;
               end
            end
            RSW_EXEC: begin
               if (must_wait) begin
                  state_reg <= RSW_WAIT;
               end else begin
                  cmd_v_reg <= 1'b0;
                  state_reg <= RSW_PARSE;
                  // query and time replies leave through the data, cr and lf states
                  if (is_relay && cmd_ok) begin
                     gap_reg    <= 1'b1; // [RULE_11]
                  end else if (cmd_reg == CHR_QUERY && chan_ok) begin
                     out_reg   <= relays_reg[chan] ? 8'h31 : 8'h30; // [RULE_09]
                     nxt_reg   <= RSW_CR;
                     state_reg <= RSW_DATA;
                  end else if (cmd_reg == CHR_TIME) begin
                     rem_reg   <= delay_reg; // [RULE_12]
                     idx_reg   <= '0;
                     dig_reg   <= '0;
                     lead_reg  <= 1'b1;
                     state_reg <= RSW_DIG;
                  end
               end
            end
            RSW_WAIT: begin
               if (ms_tick && ms_reg == 16'd1) begin
                  gap_reg   <= 1'b0;
                  state_reg <= RSW_EXEC;
               end
            end
            RSW_DIG: begin
               if (dig_more) begin
                  rem_reg <= rem_reg - pow;
                  dig_reg <= dig_reg + 1'b1;
               end else begin
                  idx_reg <= idx_reg + 1'b1;
                  dig_reg <= '0;
                  if (dig_emit) begin
                     out_reg   <= CHR_ZERO + 8'(dig_reg); // [RULE_12]
                     lead_reg  <= 1'b0;
                     nxt_reg   <= last_dig ? RSW_CR : RSW_DIG;
                     state_reg <= RSW_DATA;
                  end
               end
            end
            RSW_DATA: begin
               if (push_ok) begin
                  state_reg <= nxt_reg;
               end
            end
            RSW_CR: begin
               if (push_ok) begin
                  state_reg <= RSW_LF; // [RULE_02]
               end
            end
            RSW_LF: begin
               if (push_ok) begin
                  state_reg <= RSW_PARSE; // [RULE_02]
               end
            end
            default: begin
               state_reg    <= RSW_GET;
               rx_ready_reg <= 1'b1;
            end
         endcase
      end
   end

endmodule

//--- rtl/rsw_pkg.sv
// constants shared by the relay switch command interpreter
//
// Contract
// [RULE_01] commands end in line feed; a carriage return before it is also accepted
// [RULE_02] every reply ends with carriage return then line feed
// [RULE_03] controller sends command letters and digits exactly, case included
// [RULE_04] after power-up all 32 relays released, lamps dark, supply lamp lit
// [RULE_05] S energises every relay 0..31 and lights its lamp
// [RULE_06] R releases every relay 0..31 and darkens its lamp
// [RULE_07] C plus decimal channel energises only that relay
// [RULE_08] O plus decimal channel releases only that relay
// [RULE_09] Q plus channel replies 1 if closed, 0 if open, then terminator
// [RULE_10] channels numbered 0..31 in decimal, upper group is lower plus 16
// [RULE_11] D sets delay in ms; later relay commands in message spaced by it
// [RULE_12] T replies the programmed delay in decimal ms, then terminator
// [RULE_13] bad channel or unknown letter is ignored; relays and delay unchanged
package rsw_pkg;

   // -----------------------------------------------------------------
   // characters
   // -----------------------------------------------------------------
   localparam logic [7:0] CHR_LF    = 8'h0a;
   localparam logic [7:0] CHR_CR    = 8'h0d;
   localparam logic [7:0] CHR_ZERO  = 8'h30;
   localparam logic [7:0] CHR_NINE  = 8'h39;
   localparam logic [7:0] CHR_SET   = 8'h53;
   localparam logic [7:0] CHR_RST   = 8'h52;
   localparam logic [7:0] CHR_CLOSE = 8'h43;
   localparam logic [7:0] CHR_OPEN  = 8'h4f;
   localparam logic [7:0] CHR_QUERY = 8'h51;
   localparam logic [7:0] CHR_DELAY = 8'h44;
   localparam logic [7:0] CHR_TIME  = 8'h54;

   // -----------------------------------------------------------------
   // sizes, reset values and timing
   // -----------------------------------------------------------------
   localparam int          NUM_CHAN    = 32;
   localparam int          DELAY_W     = 16;
   localparam logic [15:0] DELAY_RST   = 16'h0000;
   localparam logic [31:0] RELAYS_RST  = 32'h0000_0000;
   localparam int          CLK_HZ      = 50_000_000;
   localparam int          MS_PER_S    = 1000;
   localparam int          CYC_PER_MS  = CLK_HZ / MS_PER_S;
   localparam int          NUM_DIGITS  = 5;

   typedef enum logic [3:0] {
      RSW_GET,
      RSW_PARSE,
      RSW_EXEC,
      RSW_WAIT,
      RSW_DIG,
      RSW_DATA,
      RSW_CR,
      RSW_LF
   } rsw_state_t;

endpackage

//--- rtl/rsw_stream_if.sv
// byte stream carrier between the interpreter and its reply buffer
`timescale 1ns/1ps
interface rsw_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

//--- rtl/rsw_buf.sv
// two-entry reply buffer; ready and valid both come from flops
`timescale 1ns/1ps
module rsw_buf (
   input  wire logic   clock_i,
   input  wire logic   rst_i,
   rsw_stream_if.snk   in_s,
   rsw_stream_if.src   out_s
);
   localparam int W = $bits(in_s.data);

   logic [W-1:0] head_reg;
   logic         head_v_reg;
   logic [W-1:0] tail_reg;
   logic         tail_v_reg;
   wire          pop  = head_v_reg & out_s.ready;
   wire          push = in_s.valid & ~tail_v_reg;

   // the second slot absorbs one word while the receiver stalls
   assign in_s.ready  = ~tail_v_reg;
   assign out_s.valid = head_v_reg;
   assign out_s.data  = head_reg;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         head_reg   <= '0;
         head_v_reg <= 1'b0;
         tail_reg   <= '0;
         tail_v_reg <= 1'b0;
      end else if (pop) begin
         if (tail_v_reg) begin
            head_reg   <= tail_reg;
            tail_v_reg <= 1'b0;
         end else begin
            head_reg   <= in_s.data;
            head_v_reg <= push;
         end
      end else if (push) begin
         if (head_v_reg) begin
            tail_reg   <= in_s.data;
            tail_v_reg <= 1'b1;
         end else begin
            head_reg   <= in_s.data;
            head_v_reg <= 1'b1;
         end
      end
   end
endmodule

//--- tb/rsw_cmd_sva.sv
// port assertions for the relay switch command interpreter
`timescale 1ns/1ps
module rsw_cmd_sva
   import rsw_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic [7:0]  rx_data_i,
   input wire logic        rx_valid_i,
   input wire logic        rx_ready_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_valid_o,
   input wire logic        tx_ready_i,
   input wire logic [31:0] relay_o,
   input wire logic [31:0] chan_lamp_o,
   input wire logic        supply_lamp_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence cr_taken;
      tx_valid_o && tx_ready_i && tx_data_o == CHR_CR;
   endsequence
   sequence lf_next;
      tx_valid_o && tx_data_o == CHR_LF;
   endsequence

   lamp_mirror_a: assert property (chan_lamp_o == relay_o)
      else $error("channel lamps differ from relays");
   reset_state_a: assert property (
      $past(rst_i) |-> rx_ready_o && !tx_valid_o && relay_o == RELAYS_RST)
      else $error("bad state after reset");
   supply_lit_a: assert property (!$past(rst_i) |-> supply_lamp_o)
      else $error("supply lamp dark");
   take_drop_a: assert property (rx_valid_i && rx_ready_o |=> !rx_ready_o)
      else $error("ready stayed high after take");
   // relays move only while a character is being handled
   relay_quiet_a: assert property (!$stable(relay_o) |-> !$past(rx_ready_o))
      else $error("relays moved while idle");
   tx_hold_a: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("reply char dropped while stalled");
   reply_end_a: assert property (cr_taken |=> lf_next)
      else $error("carriage return not followed by line feed");
   reply_digit_a: assert property (
      $rose(tx_valid_o) |-> tx_data_o inside {[CHR_ZERO:CHR_NINE]})
      else $error("reply does not start with a digit");
endmodule

bind rsw_cmd rsw_cmd_sva chk (
   .clock_i(clock_i), .rst_i(rst_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
   .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .relay_o(relay_o), .chan_lamp_o(chan_lamp_o),
   .supply_lamp_o(supply_lamp_o));

//--- tb/rsw_ctl_model.sv
// controller model: sends ascii commands, collects replies, may stall
`timescale 1ns/1ps
module rsw_ctl_model (
   input  wire logic       clock_i,
   output logic [7:0]      cmd_data_o,
   output logic            cmd_valid_o,
   input  wire logic       cmd_ready_i,
   input  wire logic [7:0] rep_data_i,
   input  wire logic       rep_valid_i,
   output logic            rep_ready_o
);
   logic [7:0] replies[$];
   logic       stall;
   logic [1:0] cnt = 2'h0;

   initial begin
      cmd_data_o  = 8'h00;
      cmd_valid_o = 1'b0;
      rep_ready_o = 1'b1;
      stall       = 1'b0;
   end

   // exact letters of either case and digits, message closed by lf
   task automatic send(input string s);
      logic r;
      for (int i = 0; i < s.len(); i++) begin
         cmd_data_o  = s[i];
         cmd_valid_o = 1'b1;
         do begin
            r = cmd_ready_i;
            @(posedge clock_i);
         end while (!r);
         #1;
      end
      cmd_valid_o = 1'b0;
      cmd_data_o  = ~cmd_data_o;
      while (!cmd_ready_i) @(posedge clock_i);
      #1;
   endtask

   // stalling receiver takes only every other pair of cycles
   always @(posedge clock_i) begin
      if (rep_valid_i && rep_ready_o) replies.push_back(rep_data_i);
      cnt <= cnt + 2'h1;
      #1 rep_ready_o = !stall || cnt[1];
   end
endmodule

//--- tb/testbench.sv
// self-checking bench for the relay switch command interpreter
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
   import rsw_pkg::*;
   localparam int CMS = 10;
   logic        clock_i;
   logic        rst_i;
   logic [7:0]  rx_data;
   logic [7:0]  tx_data;
   logic        rx_valid;
   logic        rx_ready;
   logic        tx_valid;
   logic        tx_ready;
   logic        supply;
   logic [31:0] relay;
   logic [31:0] lamp;
   int          failures;
   int          tests_run;
   time         t0;
   time         t1;

   rsw_cmd #(.CYC_MS(CMS)) uut (.clock_i(clock_i), .rst_i(rst_i), .rx_data_i(rx_data),
      .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tx_data_o(tx_data),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .relay_o(relay),
      .chan_lamp_o(lamp), .supply_lamp_o(supply));
   rsw_ctl_model ctl (.clock_i(clock_i), .cmd_data_o(rx_data), .cmd_valid_o(rx_valid),
      .cmd_ready_i(rx_ready), .rep_data_i(tx_data), .rep_valid_i(tx_valid),
      .rep_ready_o(tx_ready));

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   always @(posedge relay[0]) t0 = $time;
   always @(posedge relay[1]) t1 = $time;

   task automatic reply_is(input string s);
      int         n;
      logic [7:0] c;
      n = 0;
      while (ctl.replies.size() < s.len() && n < 300) begin
         @(posedge clock_i);
         n++;
      end
      #1;
      for (int i = 0; i < s.len(); i++) begin
         c = (ctl.replies.size() > 0) ? ctl.replies.pop_front() : 8'hxx;
         `CHK("reply char", s[i], c)
      end
   endtask

   task automatic t_power;
      `CHK("relays", RELAYS_RST, relay)
      `CHK("lamps", RELAYS_RST, lamp)
      `CHK("supply lamp", 1'b1, supply)
      $display("test power done");
   endtask

   task automatic t_all;
      ctl.send("S\n");
      `CHK("relays", 32'hffff_ffff, relay)
      `CHK("lamps", 32'hffff_ffff, lamp)
      ctl.send("R\r\n");
      `CHK("relays", 32'h0000_0000, relay)
      `CHK("lamps", 32'h0000_0000, lamp)
      $display("test set reset done");
   endtask

   task automatic t_chan;
      ctl.send("C0C21C31\n");
      `CHK("relays", 32'h8020_0001, relay)
      ctl.send("Q21\n");
      reply_is("1\r\n");
      ctl.send("O0\n");
      `CHK("relays", 32'h8020_0000, relay)
      ctl.send("Q0\r\n");
      reply_is("0\r\n");
      $display("test channels done");
   endtask

   // receiver stalls so the two-entry reply buffer fills
   task automatic t_delay;
      ctl.send("R\n");
      ctl.stall = 1'b1;
      ctl.send("D1000C0C1\n");
      `CHK("gap ok", 1'b1, (t1 - t0) / 20 inside {[1000 * CMS : 1000 * CMS + 20]})
      ctl.send("T\n");
      reply_is("1000\r\n");
      ctl.stall = 1'b0;
      $display("test delay done");
   endtask

   task automatic t_bad;
      ctl.send("C32\n");
      ctl.send("X5\n");
      ctl.send("c4O\n");
      ctl.send("D70000\n");
      `CHK("relays", 32'h0000_0003, relay)
      ctl.send("T\n");
      reply_is("1000\r\n");
      $display("test ignored commands done");
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // tests need a little over 10000 cycles, most of them the 1000 ms gap; allow ample margin
   initial begin
      repeat (40000) @(posedge clock_i);
      failures++;
      final_report;
   end

   initial begin
      failures  = 0;
      tests_run = 0;
      rst_i     = 1'b1;
      repeat (3) @(posedge clock_i);
      #1 rst_i = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      t_power;
      t_all;
      t_chan;
      t_delay;
      t_bad;
      final_report;
   end
endmodule
